// file: hw/ifpm_input_router.sv
// Input function pin router: eight functions picked from seven contacts.
// Assumes a classic Wishbone master on ref_clk_in and raw connector contacts.
//
// Contract
// - Codes 0 to 6 pick contacts 13,7,8,9,10,11,12 and a slash function is asserted while closed.
// - With codes 0 to 6 a plain function is asserted while its contact is open.
// - Codes 9 to F pick the same contacts inverted so a slash function is asserted while open.
// - With codes 9 to F a plain function is asserted while its contact is closed.
// - Code 7 holds a function asserted, but an edge-consumed function then never sees an edge.
// - Code 8 holds a function deasserted and software uses it for unused functions.
// - Functions sharing one contact each follow that one contact and respond together.
// - Each function's route and polarity is one digit of words 250A, 250B, 2511 and 2516.
// - The forward torque cap selector is bits 11:8 of word 250B.
// - The reverse torque cap selector is bits 15:12 of word 250B.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ns
`include "ifpm_params.svh"
`default_nettype none

module ifpm_input_router (
	input  wire logic                          ref_clk_in,
	input  wire logic                          reset_in,
	input  wire ifpm_pkg::ifpm_wb_req_t        wb_req_in,
	output ifpm_pkg::ifpm_wb_rsp_t             wb_rsp_out,
	input  wire logic [`IFPM_NUM_CONTACTS-1:0] contact_closed_in,
	output ifpm_pkg::ifpm_funcs_t              funcs_out,
	output ifpm_pkg::ifpm_funcs_t              func_edges_out
);
	import ifpm_pkg::*;

	localparam int NF = `IFPM_NUM_FUNCS;

	logic [15:0] input_route_word_a;
	logic [15:0] input_route_word_b;
	logic [15:0] latch_origin_route_word;
	logic [15:0] forced_halt_route_word;
	logic [`IFPM_NUM_CONTACTS-1:0] contacts;
	logic [NF-1:0] level;
	logic [NF-1:0] is_const;
	logic [NF-1:0] level_q;
	logic [NF-1:0] const_q;
	logic [3:0]    digit [NF];
	logic          slash [NF];

	// Contacts pass two flops first; the routed levels are then registered again in funcs_out
	ifpm_contact_sync #(
		.WIDTH(`IFPM_NUM_CONTACTS)
	) u_sync (
		.ref_clk_in (ref_clk_in),
		.reset_in   (reset_in),
		.async_in   (contact_closed_in),
		.sync_out   (contacts)
	);

	// Digit extraction per function
	assign digit[0] = input_route_word_a[`IFPM_DIG3 +: 4];
	assign digit[1] = input_route_word_b[`IFPM_DIG0 +: 4];
	assign digit[2] = input_route_word_b[`IFPM_DIG2 +: 4];
	assign digit[3] = input_route_word_b[`IFPM_DIG3 +: 4];
	assign digit[4] = latch_origin_route_word[`IFPM_DIG1 +: 4];
	assign digit[5] = latch_origin_route_word[`IFPM_DIG2 +: 4];
	assign digit[6] = latch_origin_route_word[`IFPM_DIG3 +: 4];
	assign digit[7] = forced_halt_route_word[`IFPM_DIG0 +: 4];

	// Slash-named functions use the active-when-closed sense by default
	assign slash[0] = 1'b0;
	assign slash[1] = 1'b0;
	assign slash[2] = 1'b1;
	assign slash[3] = 1'b1;
	assign slash[4] = 1'b1;
	assign slash[5] = 1'b1;
	assign slash[6] = 1'b1;
	assign slash[7] = 1'b0;

	// One routing slice per function; shared contacts fan out to all users
	generate
		for (genvar f = 0; f < NF; f++) begin : g_func
			ifpm_route_digit u_route (
				.digit_in     (digit[f]),
				.slash_in     (slash[f]),
				.contact_in   (contacts),
				.assert_out   (level[f]),
				.is_const_out (is_const[f])
			);
		end
	endgenerate

	// Wishbone decode; word index is the byte address divided by four
	logic [15:0] word_idx;
	logic        req;
	logic        wr;
	logic        hit_a;
	logic        hit_b;
	logic        hit_lo;
	logic        hit_fh;
	logic        hit_cs;
	logic        hit_fs;
	logic [15:0] wmask;
	logic [31:0] rd_data;

	assign word_idx = wb_req_in.adr[17:2];
	assign req      = wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack;
	assign wr       = req && wb_req_in.we;
	assign hit_a    = (word_idx == `IFPM_IDX_ROUTE_A);
	assign hit_b    = (word_idx == `IFPM_IDX_ROUTE_B);
	assign hit_lo   = (word_idx == `IFPM_IDX_LATCH_ORIGIN);
	assign hit_fh   = (word_idx == `IFPM_IDX_FORCED_HALT);
	assign hit_cs   = (word_idx == `IFPM_IDX_CONTACT_STATE);
	assign hit_fs   = (word_idx == `IFPM_IDX_FUNC_STATE);
	assign wmask    = {{8{wb_req_in.sel[1]}}, {8{wb_req_in.sel[0]}}};

	// Read mux; unmapped words read zero and still acknowledge
	assign rd_data = hit_a  ? {16'h0000, input_route_word_a} :
	                 hit_b  ? {16'h0000, input_route_word_b} :
	                 hit_lo ? {16'h0000, latch_origin_route_word} :
	                 hit_fh ? {16'h0000, forced_halt_route_word} :
	                 hit_cs ? {25'h0000000, contacts} :
	                 hit_fs ? {24'h000000, funcs_out} : 32'h00000000;

	// Write merge by byte lane
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [15:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// Route words: reset to all-unused so no function fires before setup
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			input_route_word_a      <= `IFPM_RST_ROUTE_A;
			input_route_word_b      <= `IFPM_RST_ROUTE_B;
			latch_origin_route_word <= `IFPM_RST_LATCH_ORIGIN;
			forced_halt_route_word  <= `IFPM_RST_FORCED_HALT;
		end else if (wr) begin
			if (hit_a)
				input_route_word_a <= merge(input_route_word_a, wb_req_in.dat[15:0], wmask);
			if (hit_b)
				input_route_word_b <= merge(input_route_word_b, wb_req_in.dat[15:0], wmask);
			if (hit_lo)
				latch_origin_route_word <= merge(latch_origin_route_word, wb_req_in.dat[15:0], wmask);
			if (hit_fh)
				forced_halt_route_word <= merge(forced_halt_route_word, wb_req_in.dat[15:0], wmask);
		end
	end

	// Single-cycle ack, dropped the cycle after so back-to-back needs a gap
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			wb_rsp_out <= '0;
		end else begin
			wb_rsp_out.ack <= req;
			wb_rsp_out.dat <= req ? rd_data : 32'h00000000;
		end
	end

	// Levels registered; edges are rising only and never from a constant
	logic [NF-1:0] next_edges;

	assign next_edges = level & ~level_q & ~is_const & ~const_q;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			level_q        <= '0;
			const_q        <= '1;
			funcs_out      <= '0;
			func_edges_out <= '0;
		end else begin
			level_q        <= level;
			const_q        <= is_const;
			funcs_out      <= level;
			func_edges_out <= next_edges;
		end
	end
endmodule // ifpm_input_router

`default_nettype wire

// file: hw/ifpm_params.svh
// Constants for the input function pin router: register offsets, digit
// positions, selector codes and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef IFPM_PARAMS_SVH
`define IFPM_PARAMS_SVH

// Register indices; byte address is four times the index
`define IFPM_IDX_ROUTE_A        16'h250A
`define IFPM_IDX_ROUTE_B        16'h250B
`define IFPM_IDX_LATCH_ORIGIN   16'h2511
`define IFPM_IDX_FORCED_HALT    16'h2516
`define IFPM_IDX_CONTACT_STATE  16'h2520
`define IFPM_IDX_FUNC_STATE     16'h2521

// Digit field low bit positions
`define IFPM_DIG0               0
`define IFPM_DIG1               4
`define IFPM_DIG2               8
`define IFPM_DIG3               12

// Selector codes
`define IFPM_SEL_DIRECT_MAX     4'h6
`define IFPM_SEL_FORCE_ON       4'h7
`define IFPM_SEL_FORCE_OFF      4'h8
`define IFPM_SEL_INV_BASE       4'h9

// Reset values of the route words: every function unused
`define IFPM_RST_ROUTE_A        16'h8888
`define IFPM_RST_ROUTE_B        16'h8888
`define IFPM_RST_LATCH_ORIGIN   16'h8888
`define IFPM_RST_FORCED_HALT    16'h8888

`define IFPM_NUM_CONTACTS       7
`define IFPM_NUM_FUNCS          8

`endif

// file: hw/ifpm_pkg.sv
// Types shared by the input function pin router.
// Assumes the constants header is on the include path.
`include "ifpm_params.svh"

package ifpm_pkg;

	// Classic Wishbone slave request
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [17:0] adr;
		logic [31:0] dat;
	} ifpm_wb_req_t;

	// Slave answer
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} ifpm_wb_rsp_t;

	// Routed input functions, one level each, asserted high
	typedef struct packed {
		logic forced_halt_input;
		logic origin_input;
		logic latch_input_two;
		logic latch_input_one;
		logic reverse_ext_torque_cap;
		logic forward_ext_torque_cap;
		logic reverse_travel_limit;
		logic forward_travel_limit;
	} ifpm_funcs_t;

	// Edge consumers: level or rising edge detection
	typedef enum logic {IFPM_LEVEL, IFPM_EDGE} ifpm_use_t;

endpackage : ifpm_pkg

// file: hw/ifpm_contact_sync.sv
// Two-stage synchroniser for the connector contacts.
// Assumes contact levels arrive asynchronously from the io_connector.
`timescale 1ns/1ns
`include "ifpm_params.svh"
`default_nettype none

module ifpm_contact_sync #(
	parameter int WIDTH = `IFPM_NUM_CONTACTS
) (
	input  wire logic             ref_clk_in,
	input  wire logic             reset_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	// First stage is read only by the second stage
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule // ifpm_contact_sync

`default_nettype wire

// file: hw/ifpm_route_digit.sv
// One selector digit: picks a contact or constant and applies polarity.
// Assumes synchronised contacts, 1 = closed, and a registered digit.
`timescale 1ns/1ns
`include "ifpm_params.svh"
`default_nettype none

module ifpm_route_digit (
	input  wire logic [3:0]                   digit_in,
	input  wire logic                         slash_in,
	input  wire logic [`IFPM_NUM_CONTACTS-1:0] contact_in,
	output logic                              assert_out,
	output logic                              is_const_out
);
	logic [2:0] idx;
	logic       in_direct;
	logic       in_invert;
	logic       closed;

	// Contact index from the digit; codes 0..6 and 9..F share the order
	// Constant codes point at contact 0 so the index never runs past the bank
	assign in_direct    = (digit_in <= `IFPM_SEL_DIRECT_MAX);
	assign in_invert    = (digit_in >= `IFPM_SEL_INV_BASE);
	assign idx          = in_direct ? digit_in[2:0] :
	                      in_invert ? 3'(digit_in - `IFPM_SEL_INV_BASE) : 3'h0;
	assign closed       = contact_in[idx];
	assign is_const_out = !(in_direct || in_invert);

	// Polarity: direct slash = closed, plain = open; inverted swaps
	always_comb begin
		if (in_direct)
			assert_out = slash_in ? closed : !closed;
		else if (in_invert)
			assert_out = slash_in ? !closed : closed;
		else
			assert_out = (digit_in == `IFPM_SEL_FORCE_ON);
	end
endmodule // ifpm_route_digit

`default_nettype wire

// file: testbench/ifpm_contact_bank.sv
// Behavioural bank of switch contacts on the io_connector.
// Assumes the bench chooses which contacts are pressed, on the clock edge.
`timescale 1ns/1ns
`default_nettype none
module ifpm_contact_bank (
	input  wire logic       ref_clk_in,
	input  wire logic [6:0] press_in,
	output logic      [6:0] closed_out = 7'h00
);
	// Contacts settle one clock after a press; 1 = closed, levels stand between changes
	always @(posedge ref_clk_in) begin
		closed_out <= press_in;
	end
endmodule // ifpm_contact_bank
`default_nettype wire

// file: testbench/ifpm_input_router_chk.sv
// Port assertions for the input function router.
// Assumes it is bound into ifpm_input_router, one clock domain.
`timescale 1ns/1ns
`default_nettype none
module ifpm_input_router_chk (
	input wire logic                   ref_clk_in,
	input wire logic                   reset_in,
	input wire ifpm_pkg::ifpm_wb_req_t wb_req_in,
	input wire ifpm_pkg::ifpm_wb_rsp_t wb_rsp_out,
	input wire logic [6:0]             contact_closed_in,
	input wire ifpm_pkg::ifpm_funcs_t  funcs_out,
	input wire ifpm_pkg::ifpm_funcs_t  func_edges_out
);
	import ifpm_pkg::*;
	logic [6:0] c_q;
	logic [4:0] ev;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	// Recent causes; a wide window since sync depth and write latency differ
	always_ff @(posedge ref_clk_in) begin
		c_q <= contact_closed_in;
		ev  <= {ev[3:0], (contact_closed_in != c_q) || wb_rsp_out.ack};
	end
	// A taken request gets exactly one ack pulse
	sequence s_req; $rose(wb_req_in.cyc && wb_req_in.stb); endsequence
	sequence s_ans; wb_rsp_out.ack ##1 !wb_rsp_out.ack; endsequence
	a_ack_after_req: assert property (s_req |=> s_ans) else $error("ack late");
	a_ack_one_pulse: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack) else $error("ack held");
	a_ack_has_req: assert property (wb_rsp_out.ack |-> $past(wb_req_in.stb)) else $error("stray ack");
	a_dat_idle_zero: assert property (!wb_rsp_out.ack |-> wb_rsp_out.dat == 32'h0) else $error("dat idle");
	a_dat_upper_zero: assert property (wb_rsp_out.ack |-> wb_rsp_out.dat[31:16] == 16'h0) else $error("dat hi");
	a_edge_on_rise: assert property ((func_edges_out & ~(funcs_out & ~$past(funcs_out))) == 8'h00)
		else $error("edge without rise");
	a_func_has_cause: assert property ($changed(funcs_out) |-> ev != 5'h00)
		else $error("func moved alone");
	a_reset_clears: assert property ($fell(reset_in) |-> funcs_out == 8'h00 && func_edges_out == 8'h00)
		else $error("funcs after reset");
endmodule // ifpm_input_router_chk
bind ifpm_input_router ifpm_input_router_chk u_chk (.ref_clk_in, .reset_in, .wb_req_in, .wb_rsp_out,
	.contact_closed_in, .funcs_out, .func_edges_out);
`default_nettype wire

// file: testbench/ifpm_input_router_tb.sv
// Bench for the input router: bus tasks, selector sweep, edge checks.
// Assumes the router, its bound checker and the contact bank model.
`timescale 1ns/1ns
`include "ifpm_params.svh"
`default_nettype none
module ifpm_input_router_tb;
	import ifpm_pkg::*;
	logic         ref_clk_in;
	logic         reset_in;
	ifpm_wb_req_t req;
	ifpm_wb_rsp_t rsp;
	logic [6:0]   press;
	logic [6:0]   closed;
	ifpm_funcs_t  funcs;
	ifpm_funcs_t  edges;
	logic [15:0]  r;
	logic [3:0]   cd;
	logic [3:0]   ld;
	logic [3:0]   td;
	logic [7:0]   e;
	logic         seen;
	int           err_total;
	int           n_tests;
	int           n;
	logic [15:0]  idx [4] = '{`IFPM_IDX_ROUTE_A, `IFPM_IDX_ROUTE_B, `IFPM_IDX_LATCH_ORIGIN, `IFPM_IDX_FORCED_HALT};

	ifpm_input_router DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .wb_req_in(req), .wb_rsp_out(rsp),
		.contact_closed_in(closed), .funcs_out(funcs), .func_edges_out(edges));
	ifpm_contact_bank u_bank (.ref_clk_in(ref_clk_in), .press_in(press), .closed_out(closed));

	// 250 MHz
	initial begin
		ref_clk_in = 1'b0;
		forever #2 ref_clk_in = ~ref_clk_in;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Single cycle; ack and read data are taken at the rising edge that samples ack high
	task automatic wb(input logic wr, input logic [15:0] i, input logic [15:0] d, output logic [15:0] q);
		int k;
		k = 0;
		q = 16'h0000;
		@(posedge ref_clk_in);
		req <= '{cyc: 1'b1, stb: 1'b1, we: wr, sel: 4'h3, adr: {i, 2'b00}, dat: {16'h0000, d}};
		do begin
			@(posedge ref_clk_in);
			k++;
		end while (rsp.ack !== 1'b1 && k < 20);
		if (rsp.ack !== 1'b1) begin
			err_total++;
			tally_and_finish();
		end else begin
			q = rsp.dat[15:0];
			req <= '0;
		end
	endtask

	// Expected level of one function for a digit, slash flag and contact pattern
	function automatic logic fx(input logic [3:0] c, input logic sl, input logic [6:0] p);
		if (c == 4'h7) return 1'b1;
		if (c == 4'h8) return 1'b0;
		if (c < 4'h7) return p[c[2:0]] ~^ sl;
		return p[3'(c - 4'h9)] ^ sl;
	endfunction

	initial begin
		reset_in = 1'b1;
		req = '0;
		press = 7'h00;
		err_total = 0;
		n_tests = 0;
		repeat (6) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		for (int j = 0; j < 4; j++) begin
			wb(1'b0, idx[j], 16'h0000, r);
			chk("route reset", 16'h8888, r);
		end
		chk("funcs reset", 16'h0000, {8'h00, funcs});
		wb(1'b1, 16'h2600, 16'h1234, r);
		wb(1'b0, 16'h2600, 16'h0000, r);
		chk("unmapped", 16'h0000, r);
		// Every code against each single closed contact; latch digits kept to contacts 10 to 12
		// Travel limits keep default polarity, so inverted codes map to the same contact direct
		for (int c = 0; c < 16; c++) begin
			cd = 4'(c);
			ld = (cd inside {[4'h4:4'h8], [4'hD:4'hF]}) ? cd : 4'h8;
			td = (cd >= 4'h9) ? cd - 4'h9 : cd;
			wb(1'b1, idx[0], {4{td}}, r);
			wb(1'b1, idx[1], {cd, cd, cd, td}, r);
			wb(1'b1, idx[2], {4{ld}}, r);
			wb(1'b1, idx[3], {4{cd}}, r);
			for (int k = 0; k < 7; k++) begin
				@(posedge ref_clk_in);
				press <= 7'h01 << k;
				repeat (5) @(posedge ref_clk_in);
				e = {fx(cd, 1'b0, press), {3{fx(ld, 1'b1, press)}}, {2{fx(cd, 1'b1, press)}}, {2{fx(td, 1'b0, press)}}};
				chk("funcs", {8'h00, e}, {8'h00, funcs});
				wb(1'b0, `IFPM_IDX_FUNC_STATE, 16'h0000, r);
				chk("func state", {8'h00, e}, r);
				wb(1'b0, `IFPM_IDX_CONTACT_STATE, 16'h0000, r);
				chk("contact state", {9'h000, press}, r);
			end
		end
		wb(1'b0, idx[3], 16'h0000, r);
		chk("readback", 16'hFFFF, r);
		for (int j = 0; j < 4; j++) begin
			wb(1'b1, idx[j], 16'h8888, r);
		end
		// Reverse cap on contact 13, then close it and catch the edge pulse
		wb(1'b1, idx[1], 16'h0888, r);
		repeat (5) @(posedge ref_clk_in);
		chk("cap open", 16'h0000, {8'h00, funcs});
		press <= 7'h01;
		n = 0;
		do begin
			@(negedge ref_clk_in);
			n++;
		end while (funcs[3] !== 1'b1 && n < 10);
		if (funcs[3] !== 1'b1) begin
			err_total++;
			tally_and_finish();
		end
		chk("cap edge", 16'h0001, {15'h0000, edges[3]});
		chk("rev cap", 16'h0008, {8'h00, funcs});
		wb(1'b1, idx[1], 16'h8088, r);
		repeat (2) @(posedge ref_clk_in);
		chk("fwd cap", 16'h0004, {8'h00, funcs});
		// Constant-on must raise the level yet never show an edge
		wb(1'b1, idx[1], 16'h8888, r);
		seen = 1'b0;
		wb(1'b1, idx[1], 16'h7888, r);
		repeat (4) begin
			@(negedge ref_clk_in);
			seen |= edges[3];
		end
		chk("const level", 16'h0008, {8'h00, funcs});
		chk("const edge", 16'h0000, {15'h0000, seen});
		// Reset again mid-run; held long enough that no level change lands on the release edge
		@(posedge ref_clk_in);
		reset_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		chk("funcs reset 2", 16'h0000, {8'h00, funcs});
		wb(1'b0, idx[1], 16'h0000, r);
		chk("route reset 2", 16'h8888, r);
		tally_and_finish();
	end
endmodule // ifpm_input_router_tb
`default_nettype wire
